// File: rtc_pkg.sv
package rtc_pkg;
    // serial space geometry
    localparam int unsigned ADDR_W   = 6;
    localparam logic [5:0]  ADDR_TOP = 6'h3f;
    localparam logic [5:0]  ADDR_ZERO = 6'h00;
    localparam int unsigned TIME_REGS = 8;
    localparam int unsigned CTRL_ADDR = 8;
    localparam int unsigned MEM_TOP   = 63;

    // command byte and bit counting
    localparam int unsigned DIR_BIT       = 7;
    localparam logic [2:0]  BYTE_LAST_BIT = 3'h7;

    // timekeeping register indices
    localparam logic [2:0] REG_SUBSEC = 3'h0;
    localparam logic [2:0] REG_SEC    = 3'h1;
    localparam logic [2:0] REG_MIN    = 3'h2;
    localparam logic [2:0] REG_HOUR   = 3'h3;
    localparam logic [2:0] REG_DAY    = 3'h4;
    localparam logic [2:0] REG_DATE   = 3'h5;
    localparam logic [2:0] REG_MONTH  = 3'h6;
    localparam logic [2:0] REG_YEAR   = 3'h7;

    // field positions
    localparam int unsigned HALT_BIT     = 7;
    localparam int unsigned CENT_EN_BIT  = 7;
    localparam int unsigned CENT_FLG_BIT = 6;
    localparam logic [5:0]  FREEZE_REG   = 6'h0c;
    localparam int unsigned FREEZE_BIT   = 6;

    // values after reset: year..subsec, one byte each, year on top
    localparam logic [63:0] TIME_RST = 64'h0001_0101_0000_0000;

    // timing
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned TICK_PERIOD_NS = 10_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned POWER_UP_LOCKOUT_TIME_NS = 1000;
    localparam int unsigned LOCKOUT_CYCLES =
        (POWER_UP_LOCKOUT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // write queue
    localparam int unsigned WR_FIFO_DEPTH = 16;
    localparam int unsigned WR_FIFO_W     = ADDR_W + 8;
endpackage

// File: wr_fifo.sv
`timescale 1ns/1ns
module wr_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 16
)
(
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_r [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // honest flags straight from the fill count
    assign in_ready  = count_r != (AW+1)'(DEPTH);
    assign out_valid = count_r != '0;
    assign out_data  = store_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage has no reset, only pointers and count do
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            store_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers wrap at depth, so depth need not be a power of two
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // wr_fifo

// File: rtc_serial_access_core.sv
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01 - address and data bytes shift most significant bit first
// RULE_02 - first bit after select: one means write, zero means read
// RULE_03 - bits two to eight give the address; data follows at once
// RULE_04 - pointer steps after each byte while select stays low
// RULE_05 - host raises select right after a single byte
// RULE_06 - pointer wraps from top address to zero
// RULE_07 - pointer on a time address freezes the user time copy
// RULE_08 - copy resumes on deselect or pointer leaving time addresses
// RULE_09 - internal counters keep running while the copy is frozen
// RULE_10 - supply decay deselects and blocks writes and serial input
// RULE_11 - power fail drives reset until supply is back at nominal
// RULE_12 - on battery all outputs float, time keeps running; freeze_active and write_dropped stay driven
// RULE_13 - after power returns, select inhibited and reset held a while
// RULE_14 - host holds select high for lockout time, then drives low
// RULE_15 - eight time registers in BCD: subsec, sec, min, hour first
// RULE_16 - hour bits 7,6: century enable and flag toggling at rollover
// RULE_17 - day of week in day bits 2:0, then date, month, year
// RULE_18 - seconds bit 7 halts oscillator; clearing restarts it
// RULE_19 - control register reachable alone without touching time
// RULE_20 - power failure sets the freeze bit automatically
// RULE_21 - clearing the freeze bit resumes user copy updates
// RULE_22 - input sampled on clock rise, output changes after fall
// RULE_23 - select high: deselected, serial output floats
// RULE_24 - host makes a select falling edge before any operation
// RULE_25 - address bit 6 is ignored, space is 64 bytes
// RULE_26 - power states arrive as synchronous comparator inputs
module rtc_serial_access_core
    import rtc_pkg::*;
#(
    parameter int unsigned TICK_DIV    = TICK_CYCLES,
    parameter int unsigned LOCKOUT_CNT = LOCKOUT_CYCLES,
    parameter int unsigned FIFO_DEPTH  = WR_FIFO_DEPTH
)
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic sclk,
    input  wire logic chip_sel_n,
    input  wire logic serial_in,
    input  wire logic power_fail,
    input  wire logic power_good,
    input  wire logic on_battery,
    output logic      serial_out,
    output logic      serial_out_oe_n,
    output logic      sys_reset_n,
    output logic      sys_reset_n_oe_n,
    output logic      freeze_active,
    output logic      write_dropped
);
    logic        sclk_prev_r;
    logic        cs_prev_r;
    logic        pf_prev_r;
    logic        sel_r;
    logic        armed_r;
    logic        cmd_done_r;
    logic        wr_mode_r;
    logic [2:0]  bit_cnt_r;
    logic [7:0]  rx_sh_r;
    logic [7:0]  tx_sh_r;
    logic [5:0]  ptr_r;
    logic [31:0] lock_cnt_r;
    logic [31:0] div_r;
    logic [7:0]  t_r    [0:TIME_REGS-1];
    logic [7:0]  t_nxt  [0:TIME_REGS-1];
    logic [7:0]  user_r [0:TIME_REGS-1];
    logic [7:0]  mem_r  [CTRL_ADDR:MEM_TOP];
    logic [7:0]  rx_nxt;
    logic [5:0]  ptr_inc;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        pf_rise;
    logic        byte_done;
    logic        inhibit;
    logic        halt;
    logic        tick;
    logic        freeze;
    logic        freeze_bit;
    logic        push_valid;
    logic        push_ready;
    logic        dr_valid;
    logic        pop;
    logic        wr_time;
    logic        wr_mem;
    logic [WR_FIFO_W-1:0] dr_word;
    logic [5:0]  dr_addr;
    logic [7:0]  dr_data;

    // BCD step with wrap; bit 8 is the carry out
    function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                            input logic [7:0] top,
                                            input logic [7:0] low);
        logic [7:0] n;
        n = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
        return (v == top) ? {1'b1, low} : {1'b0, n};
    endfunction

    // last date of a month; leap years by the two year digits
    function automatic logic [7:0] month_end(input logic [7:0] m,
                                             input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == 8'h02)
            return leap ? 8'h29 : 8'h28;
        if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            return 8'h30;
        return 8'h31;
    endfunction

    // reads see the frozen user copy, never the live counters
    function automatic logic [7:0] read_byte(input logic [5:0] a);
        if (a < 6'(TIME_REGS))
            return user_r[a[2:0]];
        return mem_r[a];
    endfunction

    // pin edge detection; pins are already synchronous to mclk
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sclk_prev_r <= 1'b0;
            cs_prev_r   <= 1'b0;
            pf_prev_r   <= 1'b0;
        end
        else
        begin
            sclk_prev_r <= sclk;
            cs_prev_r   <= chip_sel_n;
            pf_prev_r   <= power_fail;                        // RULE_26
        end
    end

    assign sclk_rise = sel_r & sclk & ~sclk_prev_r;           // RULE_22
    assign sclk_fall = sel_r & ~sclk & sclk_prev_r;
    assign cs_fall   = cs_prev_r & ~chip_sel_n;
    assign pf_rise   = power_fail & ~pf_prev_r;
    assign rx_nxt    = {rx_sh_r[6:0], serial_in};             // RULE_01
    assign byte_done = sclk_rise & (bit_cnt_r == BYTE_LAST_BIT);
    assign ptr_inc   = (ptr_r == ADDR_TOP) ? ADDR_ZERO : ptr_r + 6'h01;
    assign inhibit   = power_fail | ~power_good | (lock_cnt_r != '0);

    // lockout counter reloads while supply is bad, runs out after
    always_ff @(posedge mclk)
    begin
        if (sys_rst | power_fail | ~power_good)
            lock_cnt_r <= LOCKOUT_CNT;                        // RULE_13
        else if (lock_cnt_r != '0)
            lock_cnt_r <= lock_cnt_r - 32'h1;
    end

    // select must be seen high after lockout before a falling edge counts
    always_ff @(posedge mclk)
    begin
        if (sys_rst | inhibit)
            armed_r <= 1'b0;                                  // RULE_13
        else if (chip_sel_n)
            armed_r <= 1'b1;
    end

    // device selection
    always_ff @(posedge mclk)
    begin
        if (sys_rst | chip_sel_n | inhibit)
            sel_r <= 1'b0;                                    // RULE_10 RULE_23
        else if (cs_fall & armed_r)
            sel_r <= 1'b1;
    end

    // command and data shift-in; a deselect abandons a partial byte
    always_ff @(posedge mclk)
    begin
        if (sys_rst | ~sel_r)
        begin
            bit_cnt_r  <= 3'h0;
            cmd_done_r <= 1'b0;
            wr_mode_r  <= 1'b0;
            rx_sh_r    <= 8'h00;
        end
        else if (sclk_rise)
        begin
            rx_sh_r   <= rx_nxt;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_done & ~cmd_done_r)
            begin
                cmd_done_r <= 1'b1;
                wr_mode_r  <= rx_nxt[DIR_BIT];                // RULE_02
            end
        end
    end

    // address pointer; bit 6 of the command is dropped
    always_ff @(posedge mclk)
    begin
        if (sys_rst | power_fail)
            ptr_r <= ADDR_ZERO;                               // RULE_10
        else if (byte_done & ~cmd_done_r)
            ptr_r <= rx_nxt[ADDR_W-1:0];                      // RULE_03 RULE_25
        else if (byte_done)
            ptr_r <= ptr_inc;                                 // RULE_04 RULE_06
    end

    // shift-out: load at the rise ending a byte, drive on each fall
    always_ff @(posedge mclk)
    begin
        if (sys_rst | ~sel_r | on_battery)
        begin
            tx_sh_r         <= 8'h00;
            serial_out      <= 1'b0;
            serial_out_oe_n <= 1'b1;                          // RULE_12 RULE_23
        end
        else if (byte_done & ~cmd_done_r & ~rx_nxt[DIR_BIT])
            tx_sh_r <= read_byte(rx_nxt[ADDR_W-1:0]);         // RULE_03
        else if (byte_done & cmd_done_r & ~wr_mode_r)
            tx_sh_r <= read_byte(ptr_inc);                    // RULE_04
        else if (sclk_fall & cmd_done_r & ~wr_mode_r)
        begin
            serial_out      <= tx_sh_r[7];                    // RULE_01 RULE_22
            tx_sh_r         <= {tx_sh_r[6:0], 1'b0};
            serial_out_oe_n <= 1'b0;
        end
    end

    // written bytes queue up; the register side drains between ticks
    assign push_valid = byte_done & cmd_done_r & wr_mode_r
                        & ~power_fail;                        // RULE_10

    wr_fifo #(
        .WIDTH (WR_FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) i_wr_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (push_valid),
        .in_data   ({ptr_r, rx_nxt}),
        .in_ready  (push_ready),
        .out_valid (dr_valid),
        .out_data  (dr_word),
        .out_ready (~tick)
    );

    assign dr_addr = dr_word[WR_FIFO_W-1:8];
    assign dr_data = dr_word[7:0];
    assign pop     = dr_valid & ~tick;   // a tick wins, the write waits
    assign wr_time = pop & (dr_addr < 6'(TIME_REGS));
    assign wr_mem  = pop & ~(dr_addr < 6'(TIME_REGS));

    // a full queue cannot stall the host, so the loss is reported
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            write_dropped <= 1'b0;
        else
            write_dropped <= push_valid & ~push_ready;
    end

    // control, alarm and user bytes; power fail forces the freeze bit
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = CTRL_ADDR; i <= MEM_TOP; i++)
                mem_r[i] <= 8'h00;
        end
        else
        begin
            if (wr_mem)
                mem_r[dr_addr] <= dr_data;                    // RULE_19
            if (pf_rise)
                mem_r[FREEZE_REG][FREEZE_BIT] <= 1'b1;        // RULE_20
        end
    end

    assign freeze_bit = mem_r[FREEZE_REG][FREEZE_BIT];
    assign halt       = t_r[REG_SEC][HALT_BIT];               // RULE_18
    assign tick       = ~halt & (div_r == 32'(TICK_DIV - 1));

    // hundredths prescaler, held clear while the oscillator is halted
    always_ff @(posedge mclk)
    begin
        if (sys_rst | halt | tick)
            div_r <= 32'h0;                                   // RULE_18
        else
            div_r <= div_r + 32'h1;
    end

    // BCD carry chain through the calendar
    always_comb
    begin
        logic [8:0] s;
        logic       c;
        s = 9'h000;
        c = 1'b0;
        for (int i = 0; i < TIME_REGS; i++)
            t_nxt[i] = t_r[i];
        s = bcd_step(t_r[REG_SUBSEC], 8'h99, 8'h00);          // RULE_15
        t_nxt[REG_SUBSEC] = s[7:0];
        c = s[8];
        if (c)
        begin
            s = bcd_step({1'b0, t_r[REG_SEC][6:0]}, 8'h59, 8'h00);
            t_nxt[REG_SEC] = {t_r[REG_SEC][HALT_BIT], s[6:0]};
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step(t_r[REG_MIN], 8'h59, 8'h00);
            t_nxt[REG_MIN] = s[7:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step({2'b00, t_r[REG_HOUR][5:0]}, 8'h23, 8'h00);
            t_nxt[REG_HOUR] = {t_r[REG_HOUR][7:6], s[5:0]};
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step({5'h00, t_r[REG_DAY][2:0]}, 8'h07, 8'h01);
            t_nxt[REG_DAY] = {5'h00, s[2:0]};                 // RULE_17
            s = bcd_step(t_r[REG_DATE],
                         month_end(t_r[REG_MONTH], t_r[REG_YEAR]), 8'h01);
            t_nxt[REG_DATE] = s[7:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step(t_r[REG_MONTH], 8'h12, 8'h01);
            t_nxt[REG_MONTH] = s[7:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step(t_r[REG_YEAR], 8'h99, 8'h00);
            t_nxt[REG_YEAR] = s[7:0];
            if (s[8] & t_r[REG_HOUR][CENT_EN_BIT])
                t_nxt[REG_HOUR][CENT_FLG_BIT] =
                    ~t_r[REG_HOUR][CENT_FLG_BIT];             // RULE_16
        end
    end

    // live counters never stop for a frozen copy
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < TIME_REGS; i++)
                t_r[i] <= TIME_RST[8*i +: 8];
        end
        else if (wr_time)
            t_r[dr_addr[2:0]] <= dr_data;
        else if (tick)
        begin
            for (int i = 0; i < TIME_REGS; i++)
                t_r[i] <= t_nxt[i];                           // RULE_09
        end
    end

    // user copy tracks the counters unless a time access or freeze holds it
    assign freeze = (sel_r & cmd_done_r & (ptr_r < 6'(TIME_REGS)))
                    | freeze_bit;                             // RULE_07

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < TIME_REGS; i++)
                user_r[i] <= TIME_RST[8*i +: 8];
        end
        else if (~freeze)
        begin
            for (int i = 0; i < TIME_REGS; i++)
                user_r[i] <= t_r[i];                          // RULE_08 RULE_21
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            freeze_active <= 1'b0;
        else
            freeze_active <= freeze;
    end

    // open-drain reset pin: drives low, floats on battery
    assign sys_reset_n = 1'b0;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            sys_reset_n_oe_n <= 1'b0;
        else
            sys_reset_n_oe_n <= on_battery | ~inhibit;        // RULE_11 RULE_12
    end

    default clocking clk_evt @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence cmd_end_s;
        byte_done && !cmd_done_r && !power_fail;
    endsequence
    sequence tx_fall_s;
        sclk_fall && cmd_done_r && !wr_mode_r && !on_battery;
    endsequence
    sequence pf_edge_s;
        power_fail && !pf_prev_r;
    endsequence

    dir_select_a: assert property (cmd_end_s |=>  // RULE_02
        wr_mode_r == $past(rx_nxt[DIR_BIT]))
        else $error("direction bit not taken");
    addr_take_a: assert property (cmd_end_s |=>  // RULE_03
        ptr_r == $past(rx_nxt[5:0]))
        else $error("address not taken from command");
    ptr_step_a: assert property (byte_done && cmd_done_r  // RULE_04
        && !power_fail && ptr_r != ADDR_TOP |=> ptr_r == $past(ptr_r) + 6'h01)
        else $error("pointer did not advance");
    ptr_wrap_a: assert property (byte_done && cmd_done_r  // RULE_06
        && !power_fail && ptr_r == ADDR_TOP |=> ptr_r == ADDR_ZERO)
        else $error("pointer did not wrap");
    msb_out_a: assert property (tx_fall_s |=>  // RULE_01
        serial_out == $past(tx_sh_r[7]) && !serial_out_oe_n)
        else $error("output bit order wrong");
    freeze_hold_a: assert property (freeze && !wr_time |=>  // RULE_07
        $stable(user_r[REG_SEC]) && $stable(user_r[REG_SUBSEC]))
        else $error("user copy changed while frozen");
    copy_resume_a: assert property (!freeze |=>  // RULE_08
        user_r[REG_SUBSEC] == $past(t_r[REG_SUBSEC]))
        else $error("user copy not refreshed");
    keep_count_a: assert property (freeze && tick && !wr_time |=>  // RULE_09
        t_r[REG_SUBSEC] != $past(t_r[REG_SUBSEC]))
        else $error("counters stopped while frozen");
    pf_block_a: assert property (power_fail |->  // RULE_10
        !push_valid ##1 !sel_r)
        else $error("access during power fail");
    rst_drive_a: assert property (inhibit && !on_battery |=>  // RULE_11
        !sys_reset_n_oe_n)
        else $error("reset not driven");
    float_a: assert property (on_battery |=>  // RULE_12
        serial_out_oe_n && sys_reset_n_oe_n)
        else $error("output driven on battery");
    lockout_a: assert property (lock_cnt_r != '0 |=> !sel_r)  // RULE_13
        else $error("selected during lockout");
    freeze_set_a: assert property (pf_edge_s |=> freeze_bit)  // RULE_20
        else $error("freeze bit not set on power fail");
    // select drops one edge after the pin, the output enable one more
    cs_float_a: assert property (chip_sel_n |-> ##2 serial_out_oe_n) // RULE_23
        else $error("output driven while deselected");
endmodule // rtc_serial_access_core

// File: spi_host_model.sv
`timescale 1ns/1ns
// host side of the serial link, clock idles low between frames
module spi_host_model
(
    input  wire logic mclk,
    input  wire logic sdo_wire,
    output logic      sclk,
    output logic      chip_sel_n,
    output logic      serial_in
);
    // idle: deselected, clock parked low
    initial
    begin
        sclk = 1'b0;
        chip_sel_n = 1'b1;
        serial_in = 1'b0;
    end

    // one clock phase, 200 ns, well above the sampling limit
    task automatic half();
        repeat (50) @(negedge mclk);
    endtask

    task automatic sel();
        chip_sel_n = 1'b0;
        half();
    endtask

    // released data line flips so a stale bit never looks valid
    task automatic desel();
        chip_sel_n = 1'b1;
        serial_in = ~serial_in;
        half();
    endtask

    // input set while clock low, output sampled just before the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            serial_in = tx[i];
            half();
            rx[i] = sdo_wire;
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
    endtask
endmodule // spi_host_model

// File: rtc_serial_access_core_bench.sv
`timescale 1ns/1ns
module rtc_serial_access_core_bench;
    import rtc_pkg::*;
    localparam int unsigned LOCK = 8;
    logic       mclk = 1'b0;
    logic       sys_rst, sclk, chip_sel_n, serial_in;
    logic       power_fail, power_good, on_battery;
    logic       serial_out, serial_out_oe_n, sys_reset_n;
    logic       sys_reset_n_oe_n, freeze_active, write_dropped;
    logic [7:0] rx, d0;
    int         failures = 0;
    int         total_checks = 0;
    int         drops = 0;
    wire        sdo_wire = serial_out_oe_n ? 1'bz : serial_out;

    rtc_serial_access_core #(.TICK_DIV(20), .LOCKOUT_CNT(LOCK),
        .FIFO_DEPTH(16)) i_rtc_serial_access_core (
        .mclk(mclk), .sys_rst(sys_rst), .sclk(sclk),
        .chip_sel_n(chip_sel_n), .serial_in(serial_in),
        .power_fail(power_fail), .power_good(power_good),
        .on_battery(on_battery), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .sys_reset_n(sys_reset_n),
        .sys_reset_n_oe_n(sys_reset_n_oe_n),
        .freeze_active(freeze_active), .write_dropped(write_dropped));

    spi_host_model i_spi_host_model (.mclk(mclk), .sdo_wire(sdo_wire),
        .sclk(sclk), .chip_sel_n(chip_sel_n), .serial_in(serial_in));

    // 250 MHz system clock
    always #2 mclk = ~mclk;

    // lost write bytes are tallied for one compare at the end
    always @(posedge mclk)
        if (!sys_rst && write_dropped !== 1'b0)
            drops++;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic sel();
        i_spi_host_model.sel();
    endtask

    task automatic desel();
        i_spi_host_model.desel();
    endtask

    task automatic xb(input logic [7:0] t);
        i_spi_host_model.xfer(t, rx);
    endtask

    // single byte write, command bit 7 high
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sel();
        xb({1'b1, a[6:0]});
        xb(d);
        desel();
    endtask

    // single byte read, result left in rx
    task automatic rd(input logic [7:0] a);
        sel();
        xb({1'b0, a[6:0]});
        xb(8'h00);
        desel();
    endtask

    // watchdog: the whole run needs well under this
    initial
    begin
        repeat (60000) @(posedge mclk);
        failures++;
        close_out();
    end

    // test sequence
    initial
    begin
        sys_rst = 1'b1;
        power_fail = 1'b0;
        power_good = 1'b1;
        on_battery = 1'b0;
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (2) @(negedge mclk);
        check(8'(sys_reset_n_oe_n), 8'h00);
        check(8'(serial_out_oe_n), 8'h01);
        check(8'(sys_reset_n), 8'h00);
        repeat (LOCK + 40) @(negedge mclk);
        check(8'(sys_reset_n_oe_n), 8'h01);
        $display("reset test done");
        // address bit 6 set on purpose, must alias to 0x20
        wr(8'h60, 8'h55);
        rd(8'h20);
        check(rx, 8'h55);
        wr(8'h08, 8'h5a);
        rd(8'h08);
        check(rx, 8'h5a);
        $display("single byte test done");
        // halt the prescaler so address zero holds still
        wr(8'h01, 8'h80);
        sel();
        xb(8'hbf);
        xb(8'ha1);
        xb(8'h42);
        desel();
        sel();
        xb(8'h3f);
        xb(8'h00);
        check(rx, 8'ha1);
        xb(8'h00);
        check(rx, 8'h42);
        xb(8'h00);
        check(rx, 8'h80);
        desel();
        // restart: subsecond count must move between two reads
        wr(8'h01, 8'h00);
        rd(8'h00);
        d0 = rx;
        rd(8'h00);
        check(8'(rx != d0), 8'h01);
        $display("burst test done");
        sel();
        xb(8'h05);
        check(8'(freeze_active), 8'h01);
        xb(8'h00);
        check(rx, 8'h01);
        xb(8'h00);
        check(rx, 8'h01);
        xb(8'h00);
        check(rx, 8'h00);
        check(8'(freeze_active), 8'h00);
        desel();
        $display("freeze test done");
        // supply decay: write refused, then battery floats the pins
        power_fail = 1'b1;
        power_good = 1'b0;
        repeat (3) @(negedge mclk);
        check(8'(sys_reset_n_oe_n), 8'h00);
        wr(8'h20, 8'h99);
        on_battery = 1'b1;
        repeat (3) @(negedge mclk);
        check(8'(sys_reset_n_oe_n), 8'h01);
        check(8'(serial_out_oe_n), 8'h01);
        on_battery = 1'b0;
        power_fail = 1'b0;
        power_good = 1'b1;
        repeat (3) @(negedge mclk);
        check(8'(sys_reset_n_oe_n), 8'h00);
        repeat (LOCK + 40) @(negedge mclk);
        check(8'(freeze_active), 8'h01);
        rd(8'h20);
        check(rx, 8'h55);
        rd(8'h0c);
        check(rx, 8'h40);
        wr(8'h0c, 8'h00);
        rd(8'h0c);
        check(rx, 8'h00);
        check(8'(freeze_active), 8'h00);
        check(8'(drops), 8'h00);
        $display("power test done");
        close_out();
    end
endmodule // rtc_serial_access_core_bench
